// *** core/fsp_host_ctrl.v ***
// Host controller for flash sector protection and secure region
// How it works
// - Protect every unprotected sector before the elevated-voltage unprotect writes.
// - Customer lock is entry sequence then in-system protect, reset high or elevated.
// - Host exits the secure region before touching the main array.
// - Write only with select low, write strobe low, output enable high.
`timescale 1ns/1ps
`default_nettype none
`include "fsp_defines.vh"

module fsp_host_ctrl
#(
    parameter ERASE_TIMEOUT_CYC = 200000000
)
(
    // Clock and reset
    input  wire        mclk,
    input  wire        reset,
    // User command port
    input  wire        cmd_valid,
    input  wire [3:0]  cmd_code,
    input  wire [22:0] cmd_addr,
    input  wire [15:0] cmd_data,
    input  wire [63:0] cmd_password,
    output reg         cmd_ready,
    output reg         rsp_valid,
    output reg  [15:0] rsp_data,
    output reg         rsp_err,
    // User protection controls
    input  wire        boot_guard_req,
    input  wire        accel_req,
    input  wire        hv_unprotect_req,
    input  wire        all_sectors_protected,
    input  wire        supply_low,
    output reg         secure_mode,
    // Flash pins
    output wire        flash_ce_n,
    output wire        flash_we_n,
    output wire        flash_oe_n,
    output wire [22:0] flash_addr,
    output wire [15:0] flash_dq_out,
    output wire        flash_dq_oe_n,
    input  wire [15:0] flash_dq_in,
    output reg         flash_reset_n,
    output reg         flash_reset_elevated,
    output reg         boot_guard_accel_pin,
    output reg         boot_guard_accel_hv
);
    localparam S_IDLE   = 4'd0;
    localparam S_STEP   = 4'd1;
    localparam S_WAIT   = 4'd2;
    localparam S_POLLA  = 4'd3;
    localparam S_POLLB  = 4'd4;
    localparam S_VERIFY = 4'd5;
    localparam S_DELAY  = 4'd6;
    localparam S_RST    = 4'd7;
    localparam S_RECOV  = 4'd8;
    localparam S_DONE   = 4'd9;

    // Program poll limit held at the counter width
    localparam [27:0] PROG_POLL_CYC = `FSP_PROG_MAX_CYC;

    // Write step: {last, rd, addr, data}
    function [40:0] wr;
        input        last;
        input [22:0] a;
        input [15:0] d;
        begin
            wr = {last, 1'b0, a, d};
        end
    endfunction

    // Bus cycle number i of user command c
    function [40:0] step_of;
        input [3:0]  c;
        input [2:0]  i;
        input [22:0] a;
        input [15:0] d;
        input [63:0] pw;
        begin
            if (c == `FSP_CMD_READ)
                step_of = {1'b1, 1'b1, a, 16'h0000};
            else if (i == 3'd0)
                step_of = wr(1'b0, `FSP_UNLOCK_A1, `FSP_UNLOCK_D1);
            else if (i == 3'd1)
                step_of = wr(1'b0, `FSP_UNLOCK_A2, `FSP_UNLOCK_D2);
            else
                case (c)
                    `FSP_CMD_PROGRAM:
                        step_of = (i == 3'd2) ? wr(1'b0, `FSP_UNLOCK_A1, `FSP_FC_PROGRAM) : wr(1'b1, a, d);
                    `FSP_CMD_ERASE:
                        case (i)
                            3'd2:    step_of = wr(1'b0, `FSP_UNLOCK_A1, `FSP_FC_ERASE_SETUP);
                            3'd3:    step_of = wr(1'b0, `FSP_UNLOCK_A1, `FSP_UNLOCK_D1);
                            3'd4:    step_of = wr(1'b0, `FSP_UNLOCK_A2, `FSP_UNLOCK_D2);
                            default: step_of = wr(1'b1, a, `FSP_FC_SECTOR_ERASE);
                        endcase
                    `FSP_CMD_SEC_ENTER:
                        step_of = wr(1'b1, `FSP_UNLOCK_A1, `FSP_FC_SEC_ENTER);
                    `FSP_CMD_SEC_EXIT:
                        step_of = (i == 3'd2) ? wr(1'b0, `FSP_UNLOCK_A1, `FSP_FC_SEC_EXIT)
                                              : wr(1'b1, 23'h000000, `FSP_FC_EXIT_CONFIRM);
                    `FSP_CMD_LOCK_SET:
                        step_of = wr(1'b1, `FSP_UNLOCK_A1, `FSP_FC_LOCK_SET);
                    `FSP_CMD_PWD_UNLOCK:
                        // Password goes out low word first, one word per cycle
                        case (i)
                            3'd2:    step_of = wr(1'b0, `FSP_UNLOCK_A1, `FSP_FC_PWD_UNLOCK);
                            3'd3:    step_of = wr(1'b0, 23'h000000, pw[15:0]);
                            3'd4:    step_of = wr(1'b0, 23'h000001, pw[31:16]);
                            3'd5:    step_of = wr(1'b0, 23'h000002, pw[47:32]);
                            default: step_of = wr(1'b1, 23'h000003, pw[63:48]);
                        endcase
                    default:
                        // Customer lock: entry sequence, protect pair, flag read
                        case (i)
                            3'd2:    step_of = wr(1'b0, `FSP_UNLOCK_A1, `FSP_FC_SEC_ENTER);
                            3'd3:    step_of = wr(1'b0, `FSP_SEC_CUST_BASE, `FSP_FC_SEC_PROTECT);
                            3'd4:    step_of = wr(1'b0, `FSP_SEC_CUST_BASE, `FSP_FC_SEC_PROTECT);
                            default: step_of = {1'b1, 1'b1, `FSP_SEC_CUST_BASE, 16'h0000};
                        endcase
                endcase
        end
    endfunction

    reg  [3:0]  state_reg;
    reg  [3:0]  cmd_reg;
    reg  [22:0] addr_reg;
    reg  [15:0] data_reg;
    reg  [63:0] pwd_reg;
    reg  [2:0]  idx_reg;
    reg  [27:0] cnt_reg;
    reg  [15:0] prev_reg;
    reg         bus_start_reg;
    reg         bus_rd_reg;
    reg  [22:0] bus_addr_reg;
    reg  [15:0] bus_data_reg;
    wire        bus_done;
    wire [15:0] bus_rdata;
    wire [40:0] cur_step;
    wire        main_access;
    wire [27:0] poll_limit;

    assign cur_step    = step_of(cmd_reg, idx_reg, addr_reg, data_reg, pwd_reg);
    assign main_access = (cmd_code == `FSP_CMD_READ) || (cmd_code == `FSP_CMD_PROGRAM) ||
                         (cmd_code == `FSP_CMD_ERASE);
    assign poll_limit  = (cmd_reg == `FSP_CMD_ERASE) ? ERASE_TIMEOUT_CYC[27:0] : PROG_POLL_CYC;

    fsp_bus_cycle u_bus
    (
        .mclk     (mclk),
        .reset    (reset),
        .start    (bus_start_reg),
        .rd       (bus_rd_reg),
        .addr     (bus_addr_reg),
        .wdata    (bus_data_reg),
        .done     (bus_done),
        .rdata    (bus_rdata),
        .ce_n     (flash_ce_n),
        .we_n     (flash_we_n),
        .oe_n     (flash_oe_n),
        .pin_addr (flash_addr),
        .dq_out   (flash_dq_out),
        .dq_oe_n  (flash_dq_oe_n),
        .dq_in    (flash_dq_in)
    );

    always @(posedge mclk)
    begin
        if (reset)
        begin
            state_reg            <= S_IDLE;
            cmd_reg              <= `FSP_CMD_READ;
            addr_reg             <= 23'h000000;
            data_reg             <= 16'h0000;
            pwd_reg              <= 64'h0000000000000000;
            idx_reg              <= 3'd0;
            cnt_reg              <= 28'h0000000;
            prev_reg             <= 16'h0000;
            bus_start_reg        <= 1'b0;
            bus_rd_reg           <= 1'b0;
            bus_addr_reg         <= 23'h000000;
            bus_data_reg         <= 16'h0000;
            cmd_ready            <= 1'b0;
            rsp_valid            <= 1'b0;
            rsp_data             <= 16'h0000;
            rsp_err              <= 1'b0;
            secure_mode          <= 1'b0;
            flash_reset_n        <= 1'b1;
            flash_reset_elevated <= 1'b0;
            boot_guard_accel_pin <= 1'b0;
            boot_guard_accel_hv  <= 1'b0;
        end
        else
        begin
            rsp_valid     <= 1'b0;
            bus_start_reg <= 1'b0;
            // Pin low guards the boot sectors; elevated level off from the cycle after secure mode sets
            boot_guard_accel_pin <= ~boot_guard_req;
            boot_guard_accel_hv  <= accel_req && !boot_guard_req && !secure_mode;
            // Elevated reset only once every sector is protected, and only when idle
            flash_reset_elevated <= hv_unprotect_req && all_sectors_protected &&
                                    state_reg == S_IDLE;
            cmd_ready <= (state_reg == S_IDLE) && !cmd_valid && !supply_low;
            case (state_reg)
                S_IDLE:
                begin
                    if (cmd_valid && cmd_ready)
                    begin
                        cmd_reg   <= cmd_code;
                        addr_reg  <= cmd_addr;
                        data_reg  <= cmd_data;
                        pwd_reg   <= cmd_password;
                        idx_reg   <= 3'd0;
                        cnt_reg   <= 28'h0000000;
                        cmd_ready <= 1'b0;
                        // Main array stays off limits while the secure region is mapped
                        if (secure_mode && main_access && cmd_addr > `FSP_SEC_LAST)
                        begin
                            rsp_err   <= 1'b1;
                            rsp_data  <= 16'h0000;
                            rsp_valid <= 1'b1;
                        end
                        else if (cmd_code == `FSP_CMD_HW_RESET)
                            state_reg <= S_RST;
                        else if (cmd_code > `FSP_CMD_HW_RESET)
                        begin
                            rsp_err   <= 1'b1;
                            rsp_valid <= 1'b1;
                        end
                        else
                            state_reg <= S_STEP;
                    end
                end
                S_STEP:
                begin
                    bus_start_reg <= 1'b1;
                    bus_rd_reg    <= cur_step[39];
                    bus_addr_reg  <= cur_step[38:16];
                    bus_data_reg  <= cur_step[15:0];
                    state_reg     <= S_WAIT;
                end
                S_WAIT:
                begin
                    if (bus_done)
                    begin
                        if (!cur_step[40])
                        begin
                            idx_reg   <= idx_reg + 3'd1;
                            state_reg <= S_STEP;
                        end
                        else if (cmd_reg == `FSP_CMD_PROGRAM || cmd_reg == `FSP_CMD_ERASE)
                            state_reg <= S_POLLA;
                        else if (cmd_reg == `FSP_CMD_PWD_UNLOCK)
                            state_reg <= S_DELAY;
                        else
                        begin
                            rsp_data  <= bus_rdata;
                            // Customer lock succeeds only if its flag now reads one
                            rsp_err   <= (cmd_reg == `FSP_CMD_CUST_LOCK) &&
                                         !bus_rdata[`FSP_CUSTOMER_FLAG_BIT];
                            state_reg <= S_DONE;
                        end
                    end
                end
                S_POLLA, S_POLLB:
                begin
                    // Toggle polling: two reads whose bit 6 agrees mean the operation ended
                    cnt_reg <= cnt_reg + 28'h0000001;
                    if (!bus_start_reg && flash_ce_n && !bus_done)
                    begin
                        bus_start_reg <= 1'b1;
                        bus_rd_reg    <= 1'b1;
                        bus_addr_reg  <= addr_reg;
                    end
                    if (bus_done && state_reg == S_POLLA)
                    begin
                        prev_reg  <= bus_rdata;
                        state_reg <= S_POLLB;
                    end
                    else if (bus_done)
                    begin
                        if (prev_reg[`FSP_TOGGLE_BIT] == bus_rdata[`FSP_TOGGLE_BIT])
                            state_reg <= (cmd_reg == `FSP_CMD_PROGRAM) ? S_VERIFY : S_DONE;
                        else if (cnt_reg >= poll_limit)
                        begin
                            rsp_err   <= 1'b1;
                            state_reg <= S_DONE;
                        end
                        else
                            state_reg <= S_POLLA;
                        rsp_data <= bus_rdata;
                        rsp_err  <= cnt_reg >= poll_limit;
                    end
                end
                S_VERIFY:
                begin
                    // A protected sector returns quickly with old data; read back tells
                    if (!bus_start_reg && flash_ce_n && !bus_done)
                    begin
                        bus_start_reg <= 1'b1;
                        bus_rd_reg    <= 1'b1;
                        bus_addr_reg  <= addr_reg;
                    end
                    if (bus_done)
                    begin
                        rsp_data  <= bus_rdata;
                        rsp_err   <= bus_rdata != data_reg;
                        state_reg <= S_DONE;
                    end
                end
                S_DELAY:
                begin
                    // No new command until the password check time has passed
                    cnt_reg <= cnt_reg + 28'h0000001;
                    if (cnt_reg == `FSP_PWD_CYC - 1)
                    begin
                        rsp_err   <= 1'b0;
                        state_reg <= S_DONE;
                    end
                end
                S_RST:
                begin
                    flash_reset_n <= 1'b0;
                    secure_mode   <= 1'b0;
                    cnt_reg       <= cnt_reg + 28'h0000001;
                    if (cnt_reg == `FSP_RST_CYC - 1)
                    begin
                        flash_reset_n <= 1'b1;
                        cnt_reg       <= 28'h0000000;
                        state_reg     <= S_RECOV;
                    end
                end
                S_RECOV:
                begin
                    cnt_reg <= cnt_reg + 28'h0000001;
                    if (cnt_reg == `FSP_RECOV_CYC - 1)
                    begin
                        rsp_err   <= 1'b0;
                        rsp_data  <= 16'h0000;
                        state_reg <= S_DONE;
                    end
                end
                default:
                begin
                    if (cmd_reg == `FSP_CMD_SEC_ENTER || cmd_reg == `FSP_CMD_CUST_LOCK)
                        secure_mode <= 1'b1;
                    else if (cmd_reg == `FSP_CMD_SEC_EXIT)
                        secure_mode <= 1'b0;
                    rsp_valid <= 1'b1;
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end
endmodule // fsp_host_ctrl

`default_nettype wire

// *** core/fsp_defines.vh ***
// Constants of the flash protection host controller
`ifndef FSP_DEFINES_VH
`define FSP_DEFINES_VH

// Clock and cycle conversion; least times round up
`define FSP_CLK_NS            40
`define FSP_CEIL_CYC(ns)      (((ns) + `FSP_CLK_NS - 1) / `FSP_CLK_NS)

// Bus timing
`define FSP_T_WE_NS           35
`define FSP_WE_CYC            `FSP_CEIL_CYC(`FSP_T_WE_NS)
`define FSP_T_RD_NS           55
`define FSP_RD_CYC            `FSP_CEIL_CYC(`FSP_T_RD_NS)

// Password check delay
`define FSP_T_PWD_NS          2000
`define FSP_PWD_CYC           `FSP_CEIL_CYC(`FSP_T_PWD_NS)

// Reset pin pulse and recovery
`define FSP_T_RST_NS          500
`define FSP_RST_CYC           `FSP_CEIL_CYC(`FSP_T_RST_NS)
`define FSP_T_RECOV_NS        1000
`define FSP_RECOV_CYC         `FSP_CEIL_CYC(`FSP_T_RECOV_NS)

// Program status timeout
`define FSP_T_PROG_MAX_NS     128000
`define FSP_PROG_MAX_CYC      `FSP_CEIL_CYC(`FSP_T_PROG_MAX_NS)

// User commands
`define FSP_CMD_READ          4'h0
`define FSP_CMD_PROGRAM       4'h1
`define FSP_CMD_ERASE         4'h2
`define FSP_CMD_SEC_ENTER     4'h3
`define FSP_CMD_SEC_EXIT      4'h4
`define FSP_CMD_LOCK_SET      4'h5
`define FSP_CMD_PWD_UNLOCK    4'h6
`define FSP_CMD_CUST_LOCK     4'h7
`define FSP_CMD_HW_RESET      4'h8

// Flash command words and unlock addresses
`define FSP_UNLOCK_A1         23'h000555
`define FSP_UNLOCK_A2         23'h0002aa
`define FSP_UNLOCK_D1         16'h00aa
`define FSP_UNLOCK_D2         16'h0055
`define FSP_FC_PROGRAM        16'h00a0
`define FSP_FC_ERASE_SETUP    16'h0080
`define FSP_FC_SECTOR_ERASE   16'h0030
`define FSP_FC_SEC_ENTER      16'h0088
`define FSP_FC_SEC_EXIT       16'h0090
`define FSP_FC_EXIT_CONFIRM   16'h0000
`define FSP_FC_LOCK_SET       16'h0078
`define FSP_FC_PWD_UNLOCK     16'h00e0
`define FSP_FC_SEC_PROTECT    16'h0060

// Secure region layout
`define FSP_SEC_LAST          23'h00007f
`define FSP_SEC_CUST_BASE     23'h000040
`define FSP_FACTORY_FLAG_BIT  7
`define FSP_CUSTOMER_FLAG_BIT 6
`define FSP_TOGGLE_BIT        6

`endif

// *** core/fsp_bus_cycle.v ***
// One asynchronous flash bus cycle, read or write
`timescale 1ns/1ps
`default_nettype none
`include "fsp_defines.vh"

module fsp_bus_cycle
(
    // Clock and reset
    input  wire        mclk,
    input  wire        reset,
    // Request
    input  wire        start,
    input  wire        rd,
    input  wire [22:0] addr,
    input  wire [15:0] wdata,
    output reg         done,
    output reg  [15:0] rdata,
    // Flash pins
    output reg         ce_n,
    output reg         we_n,
    output reg         oe_n,
    output reg  [22:0] pin_addr,
    output reg  [15:0] dq_out,
    output reg         dq_oe_n,
    input  wire [15:0] dq_in
);
    localparam B_IDLE   = 2'd0;
    localparam B_SETUP  = 2'd1;
    localparam B_STROBE = 2'd2;
    localparam B_HOLD   = 2'd3;

    reg [1:0] state_reg;
    reg [3:0] cnt_reg;
    reg       rd_reg;

    always @(posedge mclk)
    begin
        if (reset)
        begin
            // Strobes parked high so no command is taken at power-up
            state_reg <= B_IDLE;
            cnt_reg   <= 4'h0;
            rd_reg    <= 1'b0;
            done      <= 1'b0;
            rdata     <= 16'h0000;
            ce_n      <= 1'b1;
            we_n      <= 1'b1;
            oe_n      <= 1'b1;
            pin_addr  <= 23'h000000;
            dq_out    <= 16'h0000;
            dq_oe_n   <= 1'b1;
        end
        else
        begin
            done <= 1'b0;
            case (state_reg)
                B_IDLE:
                begin
                    if (start)
                    begin
                        rd_reg    <= rd;
                        pin_addr  <= addr;
                        dq_out    <= wdata;
                        dq_oe_n   <= rd;
                        ce_n      <= 1'b0;
                        oe_n      <= 1'b1;
                        cnt_reg   <= 4'h0;
                        state_reg <= B_SETUP;
                    end
                end
                B_SETUP:
                begin
                    // Address and data settle before the strobe falls
                    if (rd_reg)
                        oe_n <= 1'b0;
                    else
                        we_n <= 1'b0;
                    state_reg <= B_STROBE;
                end
                B_STROBE:
                begin
                    cnt_reg <= cnt_reg + 4'h1;
                    if (rd_reg && cnt_reg == (`FSP_RD_CYC - 1))
                    begin
                        rdata     <= dq_in;
                        oe_n      <= 1'b1;
                        state_reg <= B_HOLD;
                    end
                    else if (!rd_reg && cnt_reg == (`FSP_WE_CYC - 1))
                    begin
                        we_n      <= 1'b1;
                        state_reg <= B_HOLD;
                    end
                end
                default:
                begin
                    ce_n      <= 1'b1;
                    dq_oe_n   <= 1'b1;
                    done      <= 1'b1;
                    state_reg <= B_IDLE;
                end
            endcase
        end
    end
endmodule // fsp_bus_cycle

`default_nettype wire

// *** tb/fsp_flash_model.sv ***
// Behavioural flash device facing the host controller
`timescale 1ns/1ps
`default_nettype none
module fsp_flash_model #(
    parameter bit PWD_MODE = 1'b0,
    parameter logic [63:0] PWD = 64'h0123456789abcdef
)(
    input wire logic ce_n, we_n, oe_n, rst_n, wp,
    input wire logic [22:0] a,
    input wire logic [15:0] d,
    output logic [15:0] q
);
    logic sec = 0, cust = 0, frz = PWD_MODE, pend = 0;
    logic [2:0] pn = 0;
    logic [63:0] pw = 0;
    logic [15:0] mem = 16'h0, v;
    always @(posedge we_n or negedge rst_n)
        if (!rst_n) begin sec <= 0; frz <= PWD_MODE; pend <= 0; pn <= 0; end
        else if (!ce_n && oe_n) begin
            if (pn != 0) begin
                // Password words arrive low word first
                pw <= {d, pw[63:16]};
                pn <= pn + 3'd1;
                if (pn == 3'd4) begin
                    pn <= 0;
                    if (PWD_MODE && {d, pw[63:16]} == PWD) frz <= 0;
                end
            end
            else if (pend) begin
                // Guard pin low keeps the two outermost 4 Kword sectors at each end
                if (wp || (a[22:13] != 0 && !(&a[22:13]))) mem <= d;
                pend <= 0;
            end
            else if (d == 16'h00a0) pend <= 1;
            else if (d == 16'h00e0) pn <= 3'd1;
            else if (d == 16'h0088) sec <= 1;
            else if (d == 16'h0090) sec <= 0;
            else if (sec && d == 16'h0060) cust <= 1;
            else if (d == 16'h0078) frz <= 1;
        end
    always_comb v = (sec && a[22:6] == 17'h1) ? {8'h0, 1'b1, cust, 6'h0} : mem;
    // Idle bus shows the inverse so a stale sample cannot pass
    assign q = (!ce_n && !oe_n) ? v : ~v;
endmodule // fsp_flash_model
`default_nettype wire

// *** tb/fsp_host_ctrl_props.sv ***
// Port assertions for the flash host controller
`timescale 1ns/1ps
`default_nettype none
module fsp_host_ctrl_props(
    input wire logic mclk, reset, cmd_valid, cmd_ready, rsp_valid, rsp_err, secure_mode,
    input wire logic [3:0] cmd_code,
    input wire logic [22:0] cmd_addr,
    input wire logic boot_guard_req, accel_req, hv_unprotect_req, all_sectors_protected, supply_low,
    input wire logic flash_ce_n, flash_we_n, flash_oe_n, flash_dq_oe_n, flash_reset_n,
    input wire logic flash_reset_elevated, boot_guard_accel_pin, boot_guard_accel_hv
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    chk_write_strobes: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n && !flash_dq_oe_n)
        else $error("write strobe misqualified");
    chk_guard_follow: assert property (!$past(reset) |-> boot_guard_accel_pin == !$past(boot_guard_req))
        else $error("guard pin wrong");
    chk_accel_gate: assert property (boot_guard_accel_hv |-> $past(accel_req && !boot_guard_req && !secure_mode))
        else $error("accel level wrong");
    chk_hv_gate: assert property ($rose(flash_reset_elevated) |-> $past(hv_unprotect_req && all_sectors_protected))
        else $error("elevated reset ungated");
    chk_lockout_ready: assert property (supply_low |=> !cmd_ready)
        else $error("ready in lockout");
    chk_secure_refuse: assert property (cmd_valid && cmd_ready && secure_mode && cmd_code < 4'h3
        && cmd_addr > 23'h7f |=> rsp_valid && rsp_err)
        else $error("secure access not refused");
    chk_reset_idle: assert property ($fell(reset) |-> flash_ce_n && flash_we_n && flash_oe_n && !cmd_ready)
        else $error("strobes active after reset");
    chk_reset_secure: assert property ($fell(flash_reset_n) |-> ##[0:60] !secure_mode)
        else $error("secure mode kept over reset");
endmodule // fsp_host_ctrl_props
bind fsp_host_ctrl fsp_host_ctrl_props fsp_host_ctrl_props_i(.mclk, .reset, .cmd_valid, .cmd_ready,
    .rsp_valid, .rsp_err, .secure_mode, .cmd_code, .cmd_addr, .boot_guard_req, .accel_req, .hv_unprotect_req,
    .all_sectors_protected, .supply_low, .flash_ce_n, .flash_we_n, .flash_oe_n, .flash_dq_oe_n,
    .flash_reset_n, .flash_reset_elevated, .boot_guard_accel_pin, .boot_guard_accel_hv);
`default_nettype wire

// *** tb/fsp_host_ctrl_tb.sv ***
// Self-checking bench for the flash host controller
`timescale 1ns/1ps
`default_nettype none
module fsp_host_ctrl_tb;
    typedef struct {logic [3:0] c; logic [22:0] a; logic [15:0] d; logic e; logic [15:0] r;} fsp_row_t;
    logic mclk = 0, reset = 1, cmd_valid = 0, boot_guard_req = 0, accel_req = 0;
    logic hv_unprotect_req = 0, all_sectors_protected = 0, supply_low = 0;
    logic [3:0] cmd_code = 0;
    logic [22:0] cmd_addr = 0, flash_addr;
    logic [15:0] cmd_data = 0, rsp_data, flash_dq_out, flash_dq_in;
    logic [63:0] cmd_password = 0;
    logic cmd_ready, rsp_valid, rsp_err, secure_mode, flash_ce_n, flash_we_n, flash_oe_n, flash_dq_oe_n;
    logic flash_reset_n, flash_reset_elevated, boot_guard_accel_pin, boot_guard_accel_hv;
    int miscompares = 0, samples_checked = 0, i;
    fsp_row_t rows[14] = '{'{3, 0, 0, 0, 0}, '{0, 23'h80, 0, 1, 0}, '{0, 23'h40, 0, 0, 16'h0080},
        '{7, 0, 0, 0, 0}, '{0, 23'h40, 0, 0, 16'h00c0}, '{9, 0, 0, 1, 0}, '{4, 0, 0, 0, 0},
        '{1, 23'h100, 16'h1234, 0, 0}, '{0, 23'h100, 0, 0, 16'h1234}, '{2, 23'h100, 0, 0, 0},
        '{5, 0, 0, 0, 0}, '{6, 0, 0, 0, 0}, '{3, 0, 0, 0, 0}, '{8, 0, 0, 0, 0}};
    fsp_host_ctrl #(.ERASE_TIMEOUT_CYC(200)) fsp_host_ctrl_i(.*);
    fsp_flash_model fsp_flash_model_i(.ce_n(flash_ce_n), .we_n(flash_we_n), .oe_n(flash_oe_n), .wp(boot_guard_accel_pin),
        .rst_n(flash_reset_n), .a(flash_addr), .d(flash_dq_out), .q(flash_dq_in));
    task cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task chk(input logic [15:0] g, e);
        samples_checked++;
        if (g !== e) begin miscompares++; $display("unexpected at %0t: got %h want %h", $time, g, e); end
    endtask
    task run(input fsp_row_t r);
        int n;
        for (n = 0; cmd_ready !== 1'b1 && n < 100; n++) cyc(1);
        cmd_code = r.c; cmd_addr = r.a; cmd_data = r.d; cmd_valid = 1;
        cyc(1);
        cmd_valid = 0;
        for (n = 0; rsp_valid !== 1'b1 && n < 5000; n++) cyc(1);
        chk(rsp_valid, 1);
        chk(rsp_err, r.e);
        if (r.c == 0) chk(rsp_data, r.r);
    endtask
    task summarize;
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial forever #20 mclk = ~mclk;
    initial begin #(40 * 30000); miscompares++; summarize; end
    initial begin
        cyc(16);
        reset = 0;
        cyc(2);
        for (i = 0; i < 14; i++) begin
            run(rows[i]);
            if (i == 11) chk(fsp_flash_model_i.frz, 1);
            $display("row %0d done", i);
        end
        chk(fsp_flash_model_i.frz, 0);
        chk(secure_mode, 0);
        boot_guard_req = 1;
        cyc(2);
        chk(boot_guard_accel_pin, 0);
        run(fsp_row_t'{1, 23'h100, 16'h5678, 1, 16'h0000});
        run(fsp_row_t'{0, 23'h100, 16'h0000, 0, 16'h1234});
        $display("guard tests done");
        boot_guard_req = 0; accel_req = 1;
        cyc(2);
        chk(boot_guard_accel_pin, 1);
        chk(boot_guard_accel_hv, 1);
        run(fsp_row_t'{3, 0, 0, 0, 0});
        cyc(2);
        chk(boot_guard_accel_hv, 0);
        reset = 1;
        cyc(2);
        reset = 0;
        chk(secure_mode, 0);
        cyc(2);
        chk(cmd_ready, 1);
        chk(boot_guard_accel_hv, 1);
        $display("reset tests done");
        hv_unprotect_req = 1;
        cyc(3);
        chk(flash_reset_elevated, 0);
        all_sectors_protected = 1;
        cyc(3);
        chk(flash_reset_elevated, 1);
        hv_unprotect_req = 0; all_sectors_protected = 0; supply_low = 1;
        cyc(3);
        chk(cmd_ready, 0);
        $display("pin tests done");
        summarize;
    end
endmodule // fsp_host_ctrl_tb
`default_nettype wire
